//--- inc/sbrg_params.svh
// constants of the serial bit-rate generator
// Overview of operation
// R1: rate register readable and writable any time
// R2: bit 7 reads zero, writes ignored
// R3: bits 6-4 pick prescaler, fed by bus clock
// R4: prescale divisor is code plus one
// R5: prescaler output drives the rate divider
// R6: software writes divider codes 0000-1000 only
// R7: rate divisor is two to code plus one
// R8: rate selections apply only in master mode
// R9: serial rate is bus over both divisors
`ifndef SBRG_PARAMS_SVH
`define SBRG_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SBRG_ADDR_W 4
`define SBRG_BR_OFFSET 4'h2
`define SBRG_BR_RESET 8'h00
`define SBRG_BR_WMASK 8'h7f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SBRG_PRE_MSB 6
`define SBRG_PRE_LSB 4
`define SBRG_DIV_MSB 3
`define SBRG_DIV_LSB 0

// ----------------------------------------------------------------
// divider limits
// ----------------------------------------------------------------
`define SBRG_DIV_MAX_CODE 4'h8
`define SBRG_DIV_CNT_W 8

`endif

//--- inc/sbrg_pkg.sv
// types of the serial bit-rate generator
package sbrg_pkg;

    typedef logic [2:0] sbrg_pre_t;
    typedef logic [3:0] sbrg_div_t;
    typedef logic [7:0] sbrg_cnt_t;

    typedef enum logic {
        SBRG_IDLE,
        SBRG_RUN
    } sbrg_mode_e;

endpackage

//--- logic/sbrg_prescaler.sv
// first stage: divide the bus clock by code plus one
`timescale 1ns/10ps
module sbrg_prescaler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire sbrg_pkg::sbrg_pre_t sel_i,
    output logic tick_o
);

    sbrg_pkg::sbrg_pre_t cnt_q;
    sbrg_pkg::sbrg_pre_t cnt_d;
    wire wrap;

    // >= so a smaller code written mid-count cannot overrun
    assign wrap = (cnt_q >= sel_i);
    assign tick_o = en_i & wrap; // R4
    assign cnt_d = (!en_i || wrap) ? 3'h0 : cnt_q + 3'h1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

//--- logic/sbrg_divider.sv
// second stage: count prescaler ticks, toggle every 2^code
`include "sbrg_params.svh"
`timescale 1ns/10ps
module sbrg_divider (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic tick_i,
    input wire sbrg_pkg::sbrg_div_t sel_i,
    output logic toggle_o
);

    sbrg_pkg::sbrg_cnt_t cnt_q;
    sbrg_pkg::sbrg_cnt_t cnt_d;
    sbrg_pkg::sbrg_div_t code;
    sbrg_pkg::sbrg_cnt_t limit;
    wire wrap;

    // reserved codes saturate at the largest divisor
    assign code = (sel_i > `SBRG_DIV_MAX_CODE) ?
                  `SBRG_DIV_MAX_CODE : sel_i; // R6
    // half period in ticks is 2^code, full period twice that
    assign limit = 8'((9'h001 << code) - 9'h001); // R7
    assign wrap = (cnt_q >= limit);
    assign toggle_o = en_i & tick_i & wrap; // R5
    assign cnt_d = !en_i ? 8'h00 :
                   !tick_i ? cnt_q :
                   wrap ? 8'h00 : cnt_q + 8'h01;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

//--- logic/sbrg_top.sv
// serial bit-rate generator: rate register and two-stage divider
//
// Design decision made here: the address-and-strobe port.
`include "sbrg_params.svh"
`timescale 1ns/10ps
module sbrg_top (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic [`SBRG_ADDR_W-1:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic MASTER_I,
    input wire logic RUN_I,
    output logic [7:0] RDATA_O,
    output logic SCK_O,
    output logic SCK_EDGE_O
);

    // ----------------------------------------------------------------
    // register access decode
    // ----------------------------------------------------------------
    wire hit;
    wire wr_hit;
    wire rd_hit;

    assign hit = (ADDR_I == `SBRG_BR_OFFSET);
    assign wr_hit = WR_I & hit;
    assign rd_hit = RD_I & hit;

    // ----------------------------------------------------------------
    // rate selection register
    // ----------------------------------------------------------------
    logic [7:0] rate_sel_q;
    logic [7:0] rate_sel_d;
    logic [7:0] rdata_d;
    sbrg_pkg::sbrg_pre_t prescale_select;
    sbrg_pkg::sbrg_div_t rate_divisor_select;

    // no busy gating: software may retune during a transfer
    assign rate_sel_d = wr_hit ? (WDATA_I & `SBRG_BR_WMASK) :
                        rate_sel_q; // R1 R2
    assign prescale_select =
        rate_sel_q[`SBRG_PRE_MSB:`SBRG_PRE_LSB]; // R3
    assign rate_divisor_select =
        rate_sel_q[`SBRG_DIV_MSB:`SBRG_DIV_LSB];
    // unmapped reads and idle cycles return zero
    assign rdata_d = rd_hit ? rate_sel_q : 8'h00; // R2

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            rate_sel_q <= `SBRG_BR_RESET;
            RDATA_O <= 8'h00;
        end else begin
            rate_sel_q <= rate_sel_d;
            RDATA_O <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    sbrg_pkg::sbrg_mode_e mode_q;
    sbrg_pkg::sbrg_mode_e mode_d;
    wire run_req;
    wire gen_en;

    // a slave shifts on the external clock, so the dividers rest
    assign run_req = MASTER_I & RUN_I; // R8

    always_comb begin
        case (mode_q)
            sbrg_pkg::SBRG_IDLE: begin
                mode_d = run_req ? sbrg_pkg::SBRG_RUN :
                         sbrg_pkg::SBRG_IDLE;
            end
            sbrg_pkg::SBRG_RUN: begin
                mode_d = run_req ? sbrg_pkg::SBRG_RUN :
                         sbrg_pkg::SBRG_IDLE;
            end
            default: begin
                mode_d = sbrg_pkg::SBRG_IDLE;
            end
        endcase
    end

    // dividers start counting the cycle after a request arrives
    assign gen_en = run_req && (mode_q == sbrg_pkg::SBRG_RUN);

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            mode_q <= sbrg_pkg::SBRG_IDLE;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ----------------------------------------------------------------
    // two cascaded dividers
    // ----------------------------------------------------------------
    logic pre_tick;
    logic half_toggle;

    sbrg_prescaler u_pre (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .en_i(gen_en),
        .sel_i(prescale_select),
        .tick_o(pre_tick)
    ); // R3 R4

    sbrg_divider u_div (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .en_i(gen_en),
        .tick_i(pre_tick),
        .sel_i(rate_divisor_select),
        .toggle_o(half_toggle)
    ); // R5 R7

    // ----------------------------------------------------------------
    // serial clock output
    // ----------------------------------------------------------------
    logic sck_d;
    logic edge_d;

    // period is prescale times rate divisor bus cycles
    assign sck_d = !gen_en ? 1'b0 : SCK_O ^ half_toggle; // R9
    assign edge_d = gen_en & half_toggle;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            SCK_O <= 1'b0;
            SCK_EDGE_O <= 1'b0;
        end else begin
            SCK_O <= sck_d;
            SCK_EDGE_O <= edge_d;
        end
    end

    // ----------------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------------
    logic [15:0] gap_q;
    logic [15:0] pre_gap_q;
    logic [8:0] tick_cnt_q;
    logic clean_q;
    logic pre_clean_q;
    logic [15:0] want_half;
    logic [8:0] want_ticks;
    logic [3:0] div_code;

    assign div_code = (rate_divisor_select > `SBRG_DIV_MAX_CODE) ?
                      `SBRG_DIV_MAX_CODE : rate_divisor_select;
    assign want_ticks = 9'h001 << div_code;
    assign want_half = 16'({13'h0000, prescale_select} + 16'h0001)
                       * 16'({7'h00, want_ticks});

    // cycles and ticks between toggles, voided by writes or stops
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || !gen_en || wr_hit) begin
            gap_q <= 16'h0000;
            tick_cnt_q <= 9'h000;
            clean_q <= 1'b0;
        end else if (half_toggle) begin
            gap_q <= 16'h0000;
            tick_cnt_q <= 9'h000;
            clean_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 16'h0001;
            tick_cnt_q <= tick_cnt_q + {8'h00, pre_tick};
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I || !gen_en || wr_hit) begin
            pre_gap_q <= 16'h0000;
            pre_clean_q <= 1'b0;
        end else if (pre_tick) begin
            pre_gap_q <= 16'h0000;
            pre_clean_q <= 1'b1;
        end else begin
            pre_gap_q <= pre_gap_q + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_WR_ANYTIME: assert property ( // R1
        @(posedge SYS_CLK_I) disable iff (RST_I)
        wr_hit |=> rate_sel_q == ($past(WDATA_I) & 8'h7f)
    ) else $error("rate register write was lost");

    AST_MSB_ZERO: assert property ( // R2
        @(posedge SYS_CLK_I) disable iff (RST_I)
        rd_hit || wr_hit |=> !RDATA_O[7] && !rate_sel_q[7]
    ) else $error("reserved top bit is not zero");

    AST_READBACK: assert property ( // R1
        @(posedge SYS_CLK_I) disable iff (RST_I)
        rd_hit |=> RDATA_O == $past(rate_sel_q)
    ) else $error("readback differs from register");

    AST_PRE_PERIOD: assert property ( // R4
        @(posedge SYS_CLK_I) disable iff (RST_I)
        pre_tick && pre_clean_q && gen_en |->
            pre_gap_q == 16'({13'h0000, prescale_select})
    ) else $error("prescaler period is not code plus one");

    AST_CASCADE: assert property ( // R5
        @(posedge SYS_CLK_I) disable iff (RST_I)
        half_toggle |-> pre_tick && gen_en
    ) else $error("divider moved without prescaler tick");

    AST_DIV_TICKS: assert property ( // R7
        @(posedge SYS_CLK_I) disable iff (RST_I)
        half_toggle && clean_q |->
            tick_cnt_q + 9'h001 == want_ticks
    ) else $error("divider half period not two to code");

    AST_SLAVE_IDLE: assert property ( // R8
        @(posedge SYS_CLK_I) disable iff (RST_I)
        !MASTER_I |=> !SCK_O && !SCK_EDGE_O
    ) else $error("serial clock runs outside master mode");

    AST_RATE: assert property ( // R9
        @(posedge SYS_CLK_I) disable iff (RST_I)
        half_toggle && clean_q |->
            gap_q + 16'h0001 == want_half
    ) else $error("serial half period is wrong");

    AST_EDGE_SCK: assert property ( // R9
        @(posedge SYS_CLK_I) disable iff (RST_I)
        SCK_EDGE_O |-> SCK_O != $past(SCK_O)
    ) else $error("edge pulse without clock change");

    AST_FASTEST: assert property ( // R4
        @(posedge SYS_CLK_I) disable iff (RST_I)
        gen_en && rate_sel_q == 8'h00 && !wr_hit ##1
            gen_en && !wr_hit |-> SCK_EDGE_O ##1 SCK_EDGE_O
    ) else $error("divide by two not toggling each cycle");

    // ----------------------------------------------------------------
    // covers
    // ----------------------------------------------------------------
    COV_SLOWEST: cover property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        half_toggle && clean_q && rate_sel_q == 8'h78
    );

    COV_RETUNE: cover property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        wr_hit && gen_en ##[1:40] half_toggle
    );

    COV_READ: cover property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        rd_hit ##1 RDATA_O != 8'h00
    );

    COV_SLAVE_DROP: cover property (
        @(posedge SYS_CLK_I) disable iff (RST_I)
        SCK_O ##1 !MASTER_I
    );

endmodule

//--- tb/sbrg_shift_model.sv
// model of the shift logic that consumes the serial clock
`timescale 1ns/10ps
module sbrg_shift_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic sck_i,
    input wire logic sck_edge_i,
    output logic run_o,
    output logic [15:0] edges_o,
    output logic [15:0] gap_o,
    output logic bad_o
);
    logic run_q;
    logic sck_prev_q;
    logic bad_q;
    logic [15:0] edges_q;
    logic [15:0] gap_q;
    logic [15:0] cnt_q;
    // ----------------------------------------------------------------
    // edge counting and half-period measurement
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        sck_prev_q <= sck_i;
        if (rst_i) begin
            bad_q <= 1'b0;
            gap_q <= 16'h0000;
        end else if (sck_edge_i !== (sck_i ^ sck_prev_q) &&
                     (run_q || sck_edge_i || sck_i)) begin
            // edge marker must sit exactly on a level change; a stop
            // pulls the clock low with no marker
            bad_q <= 1'b1;
        end
        if (rst_i || !go_i) begin
            run_q <= 1'b0;
            edges_q <= 16'h0000;
            cnt_q <= 16'h0000;
        end else begin
            run_q <= 1'b1;
            if (sck_edge_i) begin
                edges_q <= edges_q + 16'h0001;
                gap_q <= cnt_q + 16'h0001;
                cnt_q <= 16'h0000;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
    assign run_o = run_q;
    assign edges_o = edges_q;
    assign gap_o = gap_q;
    assign bad_o = bad_q;
endmodule

//--- tb/sbrg_tb_top.sv
// self-checking bench of the serial bit-rate generator
`timescale 1ns/10ps
module sbrg_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic master = 1'b0;
    logic go = 1'b0;
    logic run;
    logic [7:0] rdata;
    logic sck;
    logic sck_edge;
    logic [15:0] edges;
    logic [15:0] gap;
    logic bad;
    int n_fail = 0;
    int checks = 0;

    initial forever #2.5 clk = ~clk;

    sbrg_top sbrg_top_inst (
        .SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .MASTER_I(master), .RUN_I(run),
        .RDATA_O(rdata), .SCK_O(sck), .SCK_EDGE_O(sck_edge)
    );
    sbrg_shift_model sbrg_shift_model_inst (
        .clk_i(clk), .rst_i(rst), .go_i(go), .sck_i(sck),
        .sck_edge_i(sck_edge), .run_o(run), .edges_o(edges),
        .gap_o(gap), .bad_o(bad)
    );
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({8'h00, rdata}, {8'h00, exp}, "register read");
    endtask
    // bounded wait; the longest half period is 2048 cycles
    task automatic wait_edges(input logic [15:0] n);
        for (int k = 0; k < 10000 && edges < n; k++) begin
            @(posedge clk);
            #1;
        end
        if (edges < n) begin
            n_fail++;
            $display("[FAIL] %0t serial clock edges missing", $time);
            print_verdict();
        end
    endtask
    // stop, program, restart, then measure one half period
    task automatic run_rate(input logic [2:0] p, input logic [3:0] d);
        logic [15:0] half;
        half = (16'(p) + 16'h0001) * (16'h0001 << d);
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        wr_reg(4'h2, {1'b0, p, d});
        go <= 1'b1;
        wait_edges(16'h0003);
        chk(gap, half, "half period");
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_reg(4'h2, 8'h00);
        wr_reg(4'h2, 8'hff);
        rd_reg(4'h2, 8'h7f);
        wr_reg(4'h5, 8'h00);
        rd_reg(4'h5, 8'h00);
        rd_reg(4'h2, 8'h7f);
        // slave mode: fastest setting, so a leak would show at once
        wr_reg(4'h2, 8'h00);
        @(posedge clk);
        go <= 1'b1;
        repeat (40) @(posedge clk);
        #1;
        chk(edges, 16'h0000, "slave edges");
        chk({15'h0000, sck}, 16'h0000, "slave clock level");
        @(posedge clk);
        master <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            run_rate(3'(i), 4'h0);
        end
        for (int i = 0; i < 9; i++) begin
            run_rate(3'h0, 4'(i));
        end
        run_rate(3'h7, 4'h8);
        run_rate(3'h2, 4'h3);
        // reprogram while running: new half period of 8
        wr_reg(4'h2, 8'h03);
        wait_edges(edges + 16'h0003);
        chk(gap, 16'h0008, "half period after live write");
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk({15'h0000, sck}, 16'h0000, "idle clock level");
        chk({15'h0000, bad}, 16'h0000, "edge marker placement");
        print_verdict();
    end
endmodule
